// >>> design/uope_pkg.sv
// Package with register map, field positions and timing constants.
package uope_pkg;

    // ------------------------------------------------------------------
    // Register word offsets (byte addresses).
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_OTG_IRQ_ENABLE  = 8'h00; // Enables.
    localparam logic [7:0] ADDR_OTG_LINE_STATUS = 8'h04; // Line status.
    localparam logic [7:0] ADDR_OTG_PIN_CONTROL = 8'h08; // Pin control.
    localparam logic [7:0] ADDR_POWER_CONTROL   = 8'h0C; // Power control.
    localparam logic [7:0] ADDR_EVENT_FLAGS     = 8'h10; // Event flags.
    localparam logic [7:0] ADDR_EVENT_ENABLE    = 8'h14; // Flag enables.
    localparam logic [7:0] ADDR_ERROR_ENABLE    = 8'h18; // Error enables.

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int OTGIE_UNUSED_BIT = 1;  // Unused enable bit.
    localparam int STAT_ID_BIT      = 7;  // Cable type.
    localparam int STAT_LINE_BIT    = 5;  // Line stable.
    localparam int STAT_SESVLD_BIT  = 3;  // Session valid.
    localparam int STAT_SESSION_END_STATUS_BIT  = 2;  // Session end.
    localparam int STAT_AVBUS_BIT   = 0;  // A-device bus power valid.
    localparam int PIN_SW_CTRL_BIT  = 2;  // Pull software control.
    localparam int PWR_PEND_BIT     = 7;  // Activity pending.
    localparam int PWR_GUARD_BIT    = 4;  // Sleep entry guard.
    localparam int PWR_BUSY_BIT     = 3;  // Module busy.
    localparam int PWR_SUSP_BIT     = 1;  // Suspend request.
    localparam int PWR_ON_BIT       = 0;  // Module power on.
    localparam int FLAG_ERR_BIT     = 1;  // Error summary flag.

    // Writable masks and reset values.
    localparam logic [7:0] OTGIE_WMASK = 8'hFD; // Bit 1 unused.
    localparam logic [7:0] PWR_WMASK   = 8'h13; // Guard, suspend, on.
    localparam logic [7:0] FLAG_WMASK  = 8'hFD; // Error flag read-only.
    localparam logic [7:0] RESET_BYTE  = 8'h00; // All registers reset.

    // ------------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------------
    localparam int CLK_HZ        = 10_000_000; // System clock rate.
    localparam int LINE_STABLE_US = 1000;      // 1 ms.
    localparam int ATTACH_NS     = 2500;       // 2.5 us.
    localparam int IDLE_US       = 3000;       // 3 ms.
    localparam int BUSY_CYCLES   = 4;          // Shut-down settle time.
    // Least times round up.
    localparam int LINE_STABLE_CYC =
        (LINE_STABLE_US * (CLK_HZ / 1_000_000));
    localparam int ATTACH_CYC = (ATTACH_NS * (CLK_HZ / 1_000_000) + 999)
        / 1000;
    localparam int IDLE_CYC = IDLE_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W = 16; // Counter width.

endpackage

// >>> design/uope_regs.sv
// USB OTG power, pin control and event flag register block.
`timescale 1ns/1ns

module uope_regs #(
    parameter int LINE_STABLE_CYCLES = uope_pkg::LINE_STABLE_CYC, // 1 ms
    parameter int IDLE_CYCLES        = uope_pkg::IDLE_CYC         // 3 ms
) (
    input  wire logic       clk_sys_i,        // System clock, 10 MHz.
    input  wire logic       sys_rst_i,        // Async reset, high.
    input  wire logic [7:0] reg_addr_i,       // Register byte address.
    input  wire logic [31:0] reg_wdata_i,     // Write data.
    input  wire logic       reg_wr_i,         // Write strobe.
    input  wire logic       reg_rd_i,         // Read strobe.
    output logic      [31:0] reg_rdata_o,     // Read data, next cycle.
    input  wire logic       host_mode_i,      // 1 host, 0 device.
    input  wire logic       id_pin_i,         // Cable ID pin.
    input  wire logic       se0_i,            // Line in single-ended 0.
    input  wire logic       j_line_state_i,   // Line in J state.
    input  wire logic       k_line_state_i,   // Line in K state.
    input  wire logic       session_valid_i,  // Comparator output.
    input  wire logic       session_end_i,    // Comparator output.
    input  wire logic       a_vbus_valid_i,   // Comparator output.
    input  wire logic       bus_activity_i,   // Wake activity seen.
    input  wire logic [3:0] hw_pull_i,        // Hardware pull requests.
    input  wire logic       stall_evt_i,      // Stall sent/received.
    input  wire logic       token_done_evt_i, // Token finished.
    input  wire logic       sof_evt_i,        // SOF or threshold.
    input  wire logic       bus_reset_evt_i,  // Valid bus reset.
    input  wire logic       detach_evt_i,     // Peripheral detached.
    input  wire logic [7:0] error_flags_i,    // Individual error flags.
    input  wire logic       core_active_i,    // Core still running.
    output logic       [3:0] pull_en_o,       // D+ up, D- up, D+ dn, D- dn.
    output logic            bus_power_on_o,   // Drive bus power.
    output logic            bus_charge_o,     // Charge bus power.
    output logic            bus_discharge_o,  // Discharge bus power.
    output logic            usb_clk_en_o,     // 48 MHz clock gate.
    output logic            xcvr_low_power_o, // Transceiver low power.
    output logic            module_enable_o,  // Core and pins enabled.
    output logic            status_pop_o,     // Advance status FIFO.
    output logic            sleep_block_o,    // Blocks sleep entry.
    output logic            usb_irq_o         // Combined interrupt.
);
    import uope_pkg::*;

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0]      rdata;       // Read data register.
        logic [7:0]       otg_ie;      // OTG enables.
        logic [7:0]       pin_ctl;     // Pin control.
        logic [7:0]       pwr;         // Writable power bits.
        logic [7:0]       flags;       // Event flags (bit 1 unused).
        logic [7:0]       flag_ie;     // Event flag enables.
        logic [7:0]       err_ie;      // Error enables.
        logic             busy;        // Module busy.
        logic [2:0]       busy_cnt;    // Shut-down settle count.
        logic             pending;     // Activity pending.
        logic             line_stable; // Line stable 1 ms.
        logic [1:0]       line_prev;   // Previous SE0 and J.
        logic [CNT_W-1:0] line_cnt;    // Stable time count.
        logic [CNT_W-1:0] attach_cnt;  // Non-SE0 time count.
        logic [CNT_W-1:0] resume_cnt;  // K-state time count.
        logic [CNT_W-1:0] idle_cnt;    // Idle time count.
        logic             pop;         // FIFO advance pulse.
    } uope_state_s;

    // Two-flop synchronisers for pin-side inputs.
    logic [7:0] sync1;   // First stage.
    logic [7:0] sync2;   // Second stage.
    uope_state_s st;     // Registered state.
    uope_state_s next_st; // Next state.

    // Saturating counter increment used by all up-counting timers.
    function automatic logic [CNT_W-1:0] sat_inc(
        input logic [CNT_W-1:0] v
    );
        sat_inc = (&v) ? v : v + {{(CNT_W-1){1'b0}}, 1'b1};
    endfunction

    // ------------------------------------------------------------------
    // Input synchronisers.
    // ------------------------------------------------------------------
    // Pin levels come from the analog side, so each crosses two flops.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
        end else begin
            sync1 <= {id_pin_i, se0_i, j_line_state_i, k_line_state_i,
                      session_valid_i, session_end_i, a_vbus_valid_i,
                      bus_activity_i};
            sync2 <= sync1;
        end
    end

    logic s_id;     // Synchronised ID pin.
    logic s_se0;    // Synchronised SE0.
    logic s_j;      // Synchronised J state.
    logic s_k;      // Synchronised K state.
    logic s_sesv;   // Synchronised session valid.
    logic s_sese;   // Synchronised session end.
    logic s_avbus;  // Synchronised A-device valid.
    logic s_act;    // Synchronised activity.
    assign {s_id, s_se0, s_j, s_k, s_sesv, s_sese, s_avbus, s_act} =
        sync2;

    // Decoded write strobe, error and power levels.
    logic wr_flags;  // Write to event flags.
    assign wr_flags = reg_wr_i && (reg_addr_i == ADDR_EVENT_FLAGS);
    logic err_any;   // Enabled error present.
    assign err_any = |(error_flags_i & st.err_ie);
    logic pwr_on;    // Module powered.
    assign pwr_on = st.pwr[PWR_ON_BIT];

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0] set_v;   // Hardware set vector.
        logic [7:0] clr_v;   // Software clear vector.
        set_v = 8'h00;
        clr_v = 8'h00;
        next_st = st;
        next_st.pop = 1'b0;

        // Register writes.
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                ADDR_OTG_IRQ_ENABLE:
                    next_st.otg_ie = reg_wdata_i[7:0] & OTGIE_WMASK;
                ADDR_OTG_PIN_CONTROL:
                    next_st.pin_ctl = reg_wdata_i[7:0];
                ADDR_POWER_CONTROL:
                    next_st.pwr = reg_wdata_i[7:0] & PWR_WMASK;
                ADDR_EVENT_ENABLE:
                    next_st.flag_ie = reg_wdata_i[7:0];
                ADDR_ERROR_ENABLE:
                    next_st.err_ie = reg_wdata_i[7:0];
                default: begin
                    // Other addresses, including flags, store nothing here.
                end
            endcase
        end

        // Line stability timer restarts on any SE0 or J change.
        if ({s_se0, s_j} != st.line_prev) begin
            next_st.line_cnt = '0;
            next_st.line_stable = 1'b0;
        end else begin
            next_st.line_cnt = sat_inc(st.line_cnt);
            if (st.line_cnt >= CNT_W'(LINE_STABLE_CYCLES - 1)) begin
                next_st.line_stable = 1'b1;
            end
        end
        next_st.line_prev = {s_se0, s_j};

        // Attach and resume timers count while their condition holds.
        next_st.attach_cnt = (!s_se0) ? sat_inc(st.attach_cnt) : '0;
        next_st.resume_cnt = s_k ? sat_inc(st.resume_cnt) : '0;
        next_st.idle_cnt = (s_j && !s_se0) ? sat_inc(st.idle_cnt) : '0;

        // Events only count when the module is powered.
        if (pwr_on) begin
            set_v[7] = stall_evt_i;
            set_v[6] = host_mode_i &&
                (st.attach_cnt == CNT_W'(ATTACH_CYC - 1));
            set_v[5] = (st.resume_cnt == CNT_W'(ATTACH_CYC - 1));
            set_v[4] = (st.idle_cnt == CNT_W'(IDLE_CYCLES - 1));
            set_v[3] = token_done_evt_i;
            set_v[2] = sof_evt_i;
            set_v[0] = host_mode_i ? detach_evt_i
                                   : bus_reset_evt_i;
        end

        // Write one clears; a same-cycle set wins.
        if (wr_flags) begin
            clr_v = reg_wdata_i[7:0] & FLAG_WMASK;
        end
        next_st.flags = ((st.flags & ~clr_v) | set_v) & FLAG_WMASK;
        // Clearing a set token flag pops one status entry.
        next_st.pop = clr_v[3] && st.flags[3];

        // Activity stays pending until a cycle with the interrupt line high and no activity seen while powered and suspended.
        if (s_act && pwr_on && !st.pwr[PWR_SUSP_BIT] && usb_irq_o) begin
            next_st.pending = 1'b0;
        end else if (s_act && pwr_on) begin
            next_st.pending = 1'b1;
        end else if (usb_irq_o) begin
            next_st.pending = 1'b0;
        end

        // Busy stays up for a settle time after power is removed and the core goes idle.
        if (pwr_on || core_active_i) begin
            next_st.busy = 1'b1;
            next_st.busy_cnt = 3'(BUSY_CYCLES);
        end else if (st.busy_cnt != 3'h0) begin
            next_st.busy_cnt = st.busy_cnt - 3'h1;
        end else begin
            next_st.busy = 1'b0;
        end

        // Read data stands one cycle after the strobe.
        next_st.rdata = 32'h0000_0000;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADDR_OTG_IRQ_ENABLE: next_st.rdata[7:0] = st.otg_ie;
                ADDR_OTG_LINE_STATUS: begin
                    next_st.rdata[STAT_ID_BIT] = s_id;
                    next_st.rdata[STAT_LINE_BIT] = st.line_stable;
                    next_st.rdata[STAT_SESVLD_BIT] = s_sesv;
                    next_st.rdata[STAT_SESSION_END_STATUS_BIT] = s_sese;
                    next_st.rdata[STAT_AVBUS_BIT] = s_avbus;
                end
                ADDR_OTG_PIN_CONTROL: next_st.rdata[7:0] = st.pin_ctl;
                ADDR_POWER_CONTROL: begin
                    next_st.rdata[7:0] = st.pwr;
                    next_st.rdata[PWR_PEND_BIT] = st.pending;
                    next_st.rdata[PWR_BUSY_BIT] = st.busy;
                end
                ADDR_EVENT_FLAGS: begin
                    next_st.rdata[7:0] = st.flags;
                    next_st.rdata[FLAG_ERR_BIT] = err_any;
                end
                ADDR_EVENT_ENABLE: next_st.rdata[7:0] = st.flag_ie;
                ADDR_ERROR_ENABLE: next_st.rdata[7:0] = st.err_ie;
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    // Pull ownership: all off with the module; software field when enabled, hardware otherwise.
    always_comb begin
        if (!pwr_on) begin
            pull_en_o = 4'h0;
        end else if (st.pin_ctl[PIN_SW_CTRL_BIT]) begin
            pull_en_o = st.pin_ctl[7:4];
        end else begin
            pull_en_o = hw_pull_i;
        end
    end

    // Bus power drives follow their bits, held off with the module.
    assign bus_power_on_o  = pwr_on && st.pin_ctl[3];
    assign bus_charge_o    = pwr_on && st.pin_ctl[1];
    assign bus_discharge_o = pwr_on && st.pin_ctl[0];

    // Suspend or power-off stops the USB clock.
    assign usb_clk_en_o = pwr_on && !st.pwr[PWR_SUSP_BIT];
    assign xcvr_low_power_o = !pwr_on || st.pwr[PWR_SUSP_BIT];
    assign module_enable_o = pwr_on;
    assign status_pop_o = st.pop;
    assign reg_rdata_o = st.rdata;

    // The guard blocks sleep only while set.
    assign sleep_block_o = st.pwr[PWR_GUARD_BIT] &&
        (s_act || st.pending);

    // Combined interrupt; the error term needs both its error enables and flag enable bit 1.
    always_comb begin
        logic [7:0] eff;  // Effective flags.
        eff = st.flags;
        eff[FLAG_ERR_BIT] = err_any;
        usb_irq_o = |(eff & st.flag_ie);
    end

endmodule

// >>> sim/uope_cable_model.sv
// Cable partner model: line state, ID plug and bus power comparators.
`timescale 1ns/1ns
module uope_cable_model (
    input  wire logic       clk_sys_i, // System clock.
    input  wire logic [1:0] line_i,    // Line: 0 SE0, 1 J, 2 K.
    input  wire logic       a_plug_i,  // Type A plug inserted.
    input  wire logic       vbus_hi_i, // Bus power above valid level.
    output logic            id_pin_o,  // Low with an A plug.
    output logic      [2:0] line_o,    // SE0, J and K indications.
    output logic      [2:0] vbus_o,    // Session valid, end, A valid.
    output logic            act_o      // Wake activity, stretched.
);
    logic [1:0] last = 2'h1; // Line one clock ago.
    logic [1:0] hold = 2'h0; // Cycles of activity left.

    // One line indication at a time, so SE0 and J never overlap.
    assign line_o   = {line_i == 2'h0, line_i == 2'h1, line_i == 2'h2};
    assign id_pin_o = !a_plug_i;
    assign vbus_o   = {vbus_hi_i, !vbus_hi_i, vbus_hi_i};
    assign act_o    = (hold != 2'h0);

    // Activity is stretched so a two-flop synchroniser cannot miss it.
    always @(posedge clk_sys_i) begin
        last <= line_i;
        if (last != line_i) begin
            hold <= 2'h3;
        end else if (hold != 2'h0) begin
            hold <= hold - 2'h1;
        end
    end
endmodule

// >>> sim/uope_regs_chk.sv
// Concurrent checks on the register block, bound to every instance.
`timescale 1ns/1ns
module uope_regs_chk (
    input wire logic        clk_sys_i,        // System clock.
    input wire logic        sys_rst_i,        // Reset, high.
    input wire logic [7:0]  reg_addr_i,       // Address.
    input wire logic [31:0] reg_wdata_i,      // Write data.
    input wire logic        reg_wr_i,         // Write strobe.
    input wire logic        reg_rd_i,         // Read strobe.
    input wire logic [31:0] reg_rdata_o,      // Read data.
    input wire logic [3:0]  pull_en_o,        // Pull enables.
    input wire logic        bus_power_on_o,   // Bus power drive.
    input wire logic        bus_charge_o,     // Bus charge.
    input wire logic        bus_discharge_o,  // Bus discharge.
    input wire logic        usb_clk_en_o,     // Clock gate.
    input wire logic        xcvr_low_power_o, // Transceiver low power.
    input wire logic        module_enable_o,  // Module on.
    input wire logic        status_pop_o,     // Status advance.
    input wire logic        sleep_block_o,    // Sleep block.
    input wire logic        usb_irq_o         // Interrupt.
);
    import uope_pkg::*;
    logic       wr_q; // Write strobe one clock ago.
    logic [7:0] wa_q; // Address one clock ago.
    logic [7:0] wd_q; // Low data byte one clock ago.

    // Delayed bus copy, so no sampled function needs a bit select.
    always_ff @(posedge clk_sys_i) begin
        wr_q <= reg_wr_i;
        wa_q <= reg_addr_i;
        wd_q <= reg_wdata_i[7:0];
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    AST_OTGIE_BIT1: assert property (
        $past(reg_rd_i) && wa_q == ADDR_OTG_IRQ_ENABLE |-> !reg_rdata_o[1])
        else $error("unused enable bit read as one");
    AST_PIN_WRITE: assert property (
        reg_wr_i && reg_addr_i == ADDR_OTG_PIN_CONTROL |=>
        {bus_power_on_o, bus_charge_o, bus_discharge_o} ==
        ({wd_q[3], wd_q[1], wd_q[0]} & {3{module_enable_o}}))
        else $error("bus power drive wrong");
    AST_SW_PULL: assert property (
        reg_wr_i && reg_addr_i == ADDR_OTG_PIN_CONTROL && reg_wdata_i[2]
        && module_enable_o |=> pull_en_o == wd_q[7:4])
        else $error("software pull setting not driven");
    AST_OFF_QUIET: assert property (
        !module_enable_o |-> pull_en_o == 4'h0 && !usb_clk_en_o &&
        !bus_power_on_o && !bus_charge_o && !bus_discharge_o)
        else $error("outputs active while module off");
    AST_CLK_GATE: assert property (
        usb_clk_en_o != xcvr_low_power_o)
        else $error("clock gate and transceiver state disagree");
    AST_PWR_WRITE: assert property (
        reg_wr_i && reg_addr_i == ADDR_POWER_CONTROL |=>
        module_enable_o == wd_q[0] && usb_clk_en_o == (wd_q[0] && !wd_q[1]))
        else $error("power control write not applied");
    AST_GUARD_OFF: assert property (
        reg_wr_i && reg_addr_i == ADDR_POWER_CONTROL && !reg_wdata_i[4]
        |=> !sleep_block_o) else $error("sleep blocked with guard off");
    AST_POP_CAUSE: assert property (
        status_pop_o |-> wr_q && wa_q == ADDR_EVENT_FLAGS && wd_q[3])
        else $error("status advance without token flag clear");
    AST_IRQ_MASKED: assert property (
        reg_wr_i && reg_addr_i == ADDR_EVENT_ENABLE &&
        reg_wdata_i[7:0] == 8'h00 |=> !usb_irq_o [*2])
        else $error("interrupt with all flag enables off");
endmodule

bind uope_regs uope_regs_chk u_chk (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .pull_en_o(pull_en_o),
    .bus_power_on_o(bus_power_on_o), .bus_charge_o(bus_charge_o),
    .bus_discharge_o(bus_discharge_o), .usb_clk_en_o(usb_clk_en_o),
    .xcvr_low_power_o(xcvr_low_power_o), .module_enable_o(module_enable_o),
    .status_pop_o(status_pop_o), .sleep_block_o(sleep_block_o),
    .usb_irq_o(usb_irq_o));

// >>> sim/uope_regs_tb_top.sv
// Self-checking bench for the power, pin control and event flag block.
`timescale 1ns/1ns
module uope_regs_tb_top;
    import uope_pkg::*;
    logic        clk = 1'b0, rst = 1'b1;  // Clock and reset.
    logic [7:0]  addr = 8'h00;            // Bus address.
    logic [31:0] wdata = 32'h0, rdata, q; // Bus data.
    logic        wr = 1'b0, rd = 1'b0;    // Bus strobes.
    logic        host = 1'b0, core = 1'b0, a_plug = 1'b0, vb_hi = 1'b0;
    logic [4:0]  ev = 5'h00;              // Stall, token, SOF, reset, detach.
    logic [7:0]  err = 8'h00;             // Individual error flags.
    logic [1:0]  line = 2'h1;             // Line state, starts in J.
    logic [2:0]  ln, vb;                  // Cable indications.
    logic [3:0]  pull;                    // Pull enables.
    logic        id, act, pon, chg, dis, cke, xlp, en, pop, slp, irq;
    int          num_errors = 0, n_checks = 0, cycles = 0, pops = 0, p0;
    logic [7:0]  ebits [5] = '{8'h80, 8'h08, 8'h04, 8'h01, 8'h01};
    // Address, write data and expected read back of each table row.
    logic [71:0] rows [6] = '{
        {ADDR_OTG_IRQ_ENABLE, 32'h000000FF, 32'h000000FD},
        {ADDR_OTG_PIN_CONTROL, 32'hFFFFFFF0, 32'h000000F0},
        {ADDR_EVENT_ENABLE, 32'h000000FF, 32'h000000FF},
        {ADDR_ERROR_ENABLE, 32'h0000000F, 32'h0000000F},
        {8'h1C, 32'h000000FF, 32'h00000000},
        {ADDR_POWER_CONTROL, 32'h000000FF, 32'h0000001B}};

    uope_cable_model u_cable (.clk_sys_i(clk), .line_i(line),
        .a_plug_i(a_plug), .vbus_hi_i(vb_hi), .id_pin_o(id),
        .line_o(ln), .vbus_o(vb), .act_o(act));
    uope_regs #(.LINE_STABLE_CYCLES(20), .IDLE_CYCLES(40)) DUT (
        .clk_sys_i(clk), .sys_rst_i(rst), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .host_mode_i(host), .id_pin_i(id),
        .se0_i(ln[2]), .j_line_state_i(ln[1]), .k_line_state_i(ln[0]),
        .session_valid_i(vb[2]), .session_end_i(vb[1]),
        .a_vbus_valid_i(vb[0]), .bus_activity_i(act), .hw_pull_i(4'h5),
        .stall_evt_i(ev[0]), .token_done_evt_i(ev[1]), .sof_evt_i(ev[2]),
        .bus_reset_evt_i(ev[3]), .detach_evt_i(ev[4]), .error_flags_i(err),
        .core_active_i(core), .pull_en_o(pull), .bus_power_on_o(pon),
        .bus_charge_o(chg), .bus_discharge_o(dis), .usb_clk_en_o(cke),
        .xcvr_low_power_o(xlp), .module_enable_o(en), .status_pop_o(pop),
        .sleep_block_o(slp), .usb_irq_o(irq));

    // ------------------------------------------------------------------
    // Clock, hang guard and bus tasks.
    // ------------------------------------------------------------------
    always #50 clk = ~clk;
    // The run needs under a thousand cycles; three thousand means a hang.
    always @(posedge clk) begin
        cycles++;
        pops += (pop === 1'b1);
        if (cycles == 3000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // A gap cycle follows each write so the strobe is never set twice.
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata & m, e);
        @(posedge clk);
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Reset values, then table rows, then the awkward cases by hand.
    // ------------------------------------------------------------------
    initial begin
        wait_clk(5);
        rst <= 1'b0;
        @(posedge clk);
        #1 check({cke, xlp, en, pull}, 32'h20);
        for (int i = 0; i < 7; i++)
            if (i != 1) rd_chk(8'(i * 4), 32'hFFFFFFFF, 32'h0);
        rd_chk(ADDR_OTG_LINE_STATUS, 32'h8D, 32'h84);
        $display("reset test done");
        foreach (rows[i]) begin
            wr_reg(rows[i][71:64], rows[i][63:32]);
            rd_chk(rows[i][71:64], 32'hFFFFFFFF, rows[i][31:0]);
        end
        a_plug <= 1'b1;
        vb_hi <= 1'b1;
        wait_clk(30);
        rd_chk(ADDR_OTG_LINE_STATUS, 32'hFF, 32'h29);
        line <= 2'h0;
        wait_clk(4);
        rd_chk(ADDR_OTG_LINE_STATUS, 32'h20, 32'h0);
        $display("table and line status test done");
        #1 check(pull, 32'h5);
        wr_reg(ADDR_OTG_PIN_CONTROL, 32'hAF);
        #1 check({pull, pon, chg, dis}, 32'h57);
        check({cke, xlp}, 32'h1);
        wr_reg(ADDR_POWER_CONTROL, 32'h01);
        #1 check({cke, xlp}, 32'h2);
        $display("pin control test done");
        wr_reg(ADDR_EVENT_FLAGS, 32'hFF);
        for (int i = 0; i < 5; i++) begin
            host <= (i == 4);
            ev <= 5'h01 << i;
            @(posedge clk);
            ev <= 5'h00;
            wait_clk(2);
            rd_chk(ADDR_EVENT_FLAGS, 32'hFF, ebits[i]);
            #1 check(irq, 32'h1);
            p0 = pops;
            wr_reg(ADDR_EVENT_FLAGS, 32'h0);
            rd_chk(ADDR_EVENT_FLAGS, 32'hFF, ebits[i]);
            wr_reg(ADDR_EVENT_FLAGS, {24'h0, ebits[i]});
            rd_chk(ADDR_EVENT_FLAGS, 32'hFF, 32'h0);
            #1 check(irq, 32'h0);
            check(pops - p0, (i == 1));
        end
        err <= 8'h04;
        wr_reg(ADDR_ERROR_ENABLE, 32'h0);
        rd_chk(ADDR_EVENT_FLAGS, 32'h02, 32'h0);
        wr_reg(ADDR_ERROR_ENABLE, 32'h04);
        wr_reg(ADDR_EVENT_FLAGS, 32'h02);
        rd_chk(ADDR_EVENT_FLAGS, 32'h02, 32'h2);
        wr_reg(ADDR_EVENT_ENABLE, 32'h02);
        #1 check(irq, 32'h1);
        wr_reg(ADDR_EVENT_ENABLE, 32'hFD);
        #1 check(irq, 32'h0);
        err <= 8'h00;
        $display("event flag test done");
        wr_reg(ADDR_EVENT_FLAGS, 32'hFF);
        line <= 2'h1;
        wait_clk(16);
        rd_chk(ADDR_EVENT_FLAGS, 32'h40, 32'h0);
        wait_clk(12);
        rd_chk(ADDR_EVENT_FLAGS, 32'h50, 32'h40);
        wait_clk(20);
        rd_chk(ADDR_EVENT_FLAGS, 32'h10, 32'h10);
        line <= 2'h2;
        wait_clk(30);
        rd_chk(ADDR_EVENT_FLAGS, 32'h20, 32'h20);
        $display("line timing test done");
        wr_reg(ADDR_EVENT_ENABLE, 32'h0);
        wr_reg(ADDR_POWER_CONTROL, 32'h11);
        line <= 2'h1;
        wait_clk(6);
        rd_chk(ADDR_POWER_CONTROL, 32'hFF, 32'h99);
        #1 check(slp, 32'h1);
        wr_reg(ADDR_POWER_CONTROL, 32'h01);
        #1 check(slp, 32'h0);
        core <= 1'b1;
        wr_reg(ADDR_POWER_CONTROL, 32'h0);
        wait_clk(10);
        rd_chk(ADDR_POWER_CONTROL, 32'h08, 32'h08);
        core <= 1'b0;
        wait_clk(8);
        rd_chk(ADDR_POWER_CONTROL, 32'h08, 32'h0);
        #1 check({pull, pon, chg, dis, cke}, 32'h0);
        $display("power and busy test done");
        rst <= 1'b1;
        wait_clk(2);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(ADDR_OTG_PIN_CONTROL, 32'hFF, 32'h0);
        $display("mid-run reset test done");
        report_and_stop();
    end
endmodule
